// File: sim/ppsc_periph.sv
`timescale 1ns/1ps
// ****************************************
// Peripheral side: pin levels and EPP answer
// ****************************************
module ppsc_periph (
   input wire mclk_i,
   input wire epp_start_i,
   input wire [9:0] delay_i,
   output reg epp_cycle_o,
   output reg [5:0] lines_o
);
   integer cnt;
   initial begin
      epp_cycle_o = 1'b0;
      lines_o = 6'h00;
      cnt = 0;
   end
   // A delay past the host limit stands for a dead peripheral
   always @(posedge mclk_i) begin
      if (epp_start_i) begin
         epp_cycle_o <= 1'b1;
         cnt <= delay_i;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end else begin
         epp_cycle_o <= 1'b0;
      end
   end
   task set_lines(input [5:0] v);
      lines_o = v;
   endtask
endmodule

// File: sim/ppsc_regs_asserts.sv
`timescale 1ns/1ps
// ****************************************
// Port checks
// ****************************************
module ppsc_regs_chk (
   input wire mclk_i,
   input wire nrst_i,
   input wire [2:0] addr_i,
   input wire rd_i,
   input wire wr_i,
   input wire [7:0] wdata_i,
   input wire [2:0] mode_i,
   input wire epp_cycle_i,
   input wire [7:0] rdata_o,
   input wire nstrobe_o,
   input wire nautofd_o,
   input wire ninit_o,
   input wire nselectin_o,
   input wire data_in_o,
   input wire epp_timeout_irq_o,
   input wire [15:0] irq_report_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   sequence ctl_wr;
      wr_i && addr_i == 3'h2;
   endsequence
   sequence epp_quiet;
      $rose(epp_cycle_i) ##1 !irq_report_o[0];
   endsequence
   strobe_drive_a: assert property (ctl_wr |-> ##2 nstrobe_o == !$past(wdata_i[0], 2))
      else $error("nstrobe mismatch");
   autofd_drive_a: assert property (ctl_wr |-> ##2 nautofd_o == !$past(wdata_i[1], 2))
      else $error("nautofd mismatch");
   ninit_drive_a: assert property (ctl_wr |-> ##2 ninit_o == $past(wdata_i[2], 2))
      else $error("ninit mismatch");
   selin_drive_a: assert property (ctl_wr |-> ##2 nselectin_o == !$past(wdata_i[3], 2))
      else $error("nselectin mismatch");
   rsvd_bit_a: assert property (rd_i && addr_i == 3'h1 |=> rdata_o[2] == 1'b0)
      else $error("reserved bit set");
   rdata_hold_a: assert property (!rd_i |=> $stable(rdata_o)) else $error("read data moved");
   mask_block_a: assert property ($rose(epp_timeout_irq_o) |-> !irq_report_o[14])
      else $error("masked timeout raised");
   early_timeout_a: assert property (epp_quiet |=> !irq_report_o[0] [*8])
      else $error("timeout too early");
   dir_fixed_a: assert property ((mode_i == 3'h0 || mode_i == 3'h2) [*2] |-> !data_in_o)
      else $error("output-only mode turned");
endmodule
bind ppsc_regs ppsc_regs_chk u_chk (.*);

// File: sim/ppsc_regs_tb_top.sv
`timescale 1ns/1ps
module ppsc_regs_tb_top;
   reg mclk_i = 1'b0;
   reg nrst_i = 1'b0;
   reg [2:0] addr_i = 3'h0;
   reg rd_i = 1'b0;
   reg wr_i = 1'b0;
   reg [7:0] wdata_i = 8'h00;
   reg [2:0] mode_i = 3'h0;
   reg epp_read_i = 1'b0;
   reg epp_start = 1'b0;
   reg [9:0] delay = 10'h005;
   reg [31:0] tv = 32'h810F2A55;
   reg [7:0] d;
   reg [5:0] v;
   wire epp_cycle;
   wire [5:0] ln;
   wire [7:0] rdata_o;
   wire hlh_o, nselectin_o, ninit_o, nautofd_o, nstrobe_o, data_in_o;
   wire epp_timeout_irq_o, ack_edge_irq_flag_o;
   wire [15:0] irq_report_o;
   integer fails = 0;
   integer num_checks = 0;
   integer i;
   always #20 mclk_i = ~mclk_i;
   ppsc_periph P (.mclk_i(mclk_i), .epp_start_i(epp_start), .delay_i(delay),
      .epp_cycle_o(epp_cycle), .lines_o(ln));
   ppsc_regs DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .rd_i(rd_i),
      .wr_i(wr_i), .wdata_i(wdata_i), .mode_i(mode_i), .epp_read_i(epp_read_i),
      .epp_cycle_i(epp_cycle), .busy_i(ln[5]), .nack_i(ln[4]),
      .perror_i(ln[3]), .select_i(ln[2]), .nfault_i(ln[1]), .plh_i(ln[0]),
      .rdata_o(rdata_o), .hlh_o(hlh_o), .nselectin_o(nselectin_o), .ninit_o(ninit_o),
      .nautofd_o(nautofd_o), .nstrobe_o(nstrobe_o), .data_in_o(data_in_o),
      .epp_timeout_irq_o(epp_timeout_irq_o), .ack_edge_irq_flag_o(ack_edge_irq_flag_o),
      .irq_report_o(irq_report_o));
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge mclk_i);
   endtask
   task wr(input [2:0] a, input [7:0] x);
      begin
         addr_i = a;
         wdata_i = x;
         wr_i = 1'b1;
         cyc(1);
         wr_i = 1'b0;
         cyc(2);
      end
   endtask
   task rd(input [2:0] a);
      begin
         addr_i = a;
         rd_i = 1'b1;
         cyc(1);
         rd_i = 1'b0;
      end
   endtask
   task epp(input [9:0] n);
      begin
         delay = n;
         epp_start = 1'b1;
         cyc(1);
         epp_start = 1'b0;
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d fails %0d", num_checks, fails);
         if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      #200000;
      fails = fails + 1;
      give_verdict;
   end
   initial begin
      cyc(6);
      nrst_i = 1'b1;
      cyc(1);
      rd(3'h2);
      chk(rdata_o, 8'h4C);
      chk({hlh_o, nselectin_o, ninit_o, nautofd_o, nstrobe_o}, 5'h07);
      for (i = 0; i < 4; i = i + 1) begin
         d = tv[8*i +: 8];
         wr(3'h2, d);
         rd(3'h2);
         chk(rdata_o, d);
         chk({hlh_o, nselectin_o, ninit_o, nautofd_o, nstrobe_o},
            {d[7], ~d[3], d[2], ~d[1], ~d[0]});
         chk(irq_report_o[15:8], d);
      end
      for (i = 0; i < 2; i = i + 1) begin
         v = i ? 6'h15 : 6'h2A;
         P.set_lines(v);
         cyc(4);
         wr(3'h1, 8'hFF);
         rd(3'h1);
         chk(rdata_o, {~v[5], v[4:1], 1'b0, v[0], 1'b0});
         chk(irq_report_o[7:0], {~v[5], v[4:1], 1'b0, v[0], 1'b0});
      end
      rd(3'h5);
      chk(rdata_o, 8'h00);
      // Interrupt enable on, then off: only the first may flag
      for (i = 0; i < 2; i = i + 1) begin
         wr(3'h2, i ? 8'h00 : 8'h10);
         P.set_lines(6'h00);
         cyc(4);
         rd(3'h0);
         P.set_lines(6'h10);
         cyc(6);
         chk(ack_edge_irq_flag_o, i ? 1'b0 : 1'b1);
         rd(3'h2);
         cyc(1);
         chk(ack_edge_irq_flag_o, 1'b0);
      end
      mode_i = 3'h4;
      epp_read_i = 1'b1;
      wr(3'h2, 8'h10);
      epp(10'd400);
      cyc(4);
      chk(data_in_o, 1'b1);
      cyc(236);
      chk(irq_report_o[0], 1'b0);
      cyc(20);
      chk(epp_timeout_irq_o, 1'b1);
      rd(3'h1);
      chk(rdata_o[0], 1'b1);
      cyc(1);
      rd(3'h1);
      chk(rdata_o[0], 1'b0);
      chk(epp_timeout_irq_o, 1'b0);
      cyc(160);
      epp_read_i = 1'b0;
      wr(3'h2, 8'h50);
      epp(10'd400);
      cyc(4);
      chk(data_in_o, 1'b0);
      cyc(261);
      chk(epp_timeout_irq_o, 1'b0);
      rd(3'h1);
      chk(rdata_o[0], 1'b1);
      cyc(150);
      wr(3'h2, 8'h10);
      epp(10'd5);
      cyc(265);
      chk(irq_report_o[0], 1'b0);
      wr(3'h2, 8'h20);
      for (i = 0; i < 4; i = i + 1) begin
         mode_i = i;
         cyc(3);
         chk(data_in_o, i[0]);
      end
      give_verdict;
   end
endmodule

// File: src/ppsc_consts.vh
`ifndef PPSC_CONSTS_VH
`define PPSC_CONSTS_VH

// ***********************************************
// Register addresses
// ***********************************************
`define PPSC_ADDR_W 3
`define PPSC_ADDR_STATUS 3'h1
`define PPSC_ADDR_CONTROL 3'h2

// ***********************************************
// Status fields
// ***********************************************
`define PPSC_ST_NBUSY 7
`define PPSC_ST_NACK 6
`define PPSC_ST_PERROR 5
`define PPSC_ST_SELECT 4
`define PPSC_ST_NFAULT 3
`define PPSC_ST_RSVD 2
`define PPSC_ST_PLH 1
`define PPSC_ST_TIMEOUT 0
// Pin synchroniser reset, ordered busy, nack, perror, select, nfault, plh
`define PPSC_PIN_RESET 6'h10

// ***********************************************
// Control fields and reset
// ***********************************************
`define PPSC_CT_HLH 7
`define PPSC_CT_EPP_TIMEOUT_IRQ_MASK 6
`define PPSC_CT_DIR 5
`define PPSC_CT_INT_EN 4
`define PPSC_CT_SELIN 3
`define PPSC_CT_NINIT 2
`define PPSC_CT_AUTOFD 1
`define PPSC_CT_STROBE 0
`define PPSC_CONTROL_RESET 8'h4C

// ***********************************************
// Interface modes
// ***********************************************
`define PPSC_MODE_STD 3'h0
`define PPSC_MODE_BIDIR 3'h1
`define PPSC_MODE_COMPAT 3'h2
`define PPSC_MODE_ECP 3'h3
`define PPSC_MODE_EPP 3'h4

// ***********************************************
// Timing: EPP time-out, 10 us at 25 MHz
// ***********************************************
`define PPSC_TIMEOUT_NS 10000
`define PPSC_CLK_NS 40
`define PPSC_TIMEOUT_CYC (`PPSC_TIMEOUT_NS / `PPSC_CLK_NS)
`define PPSC_CNT_W 9

`endif

// File: src/ppsc_regs.v
`timescale 1ns/1ps
`include "ppsc_consts.vh"

module ppsc_regs (
   input wire mclk_i,
   input wire nrst_i,
   input wire [`PPSC_ADDR_W-1:0] addr_i,
   input wire rd_i,
   input wire wr_i,
   input wire [7:0] wdata_i,
   input wire [2:0] mode_i,
   input wire epp_cycle_i,
   input wire epp_read_i,
   input wire busy_i,
   input wire nack_i,
   input wire perror_i,
   input wire select_i,
   input wire nfault_i,
   input wire plh_i,
   output reg [7:0] rdata_o,
   output reg hlh_o,
   output reg nselectin_o,
   output reg ninit_o,
   output reg nautofd_o,
   output reg nstrobe_o,
   output reg data_in_o,
   output reg epp_timeout_irq_o,
   output reg ack_edge_irq_flag_o,
   output reg [15:0] irq_report_o
);

   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   wire [5:0] pin_raw;
   wire [5:0] pin_s2;
   wire [1:0] epp_raw;
   wire [1:0] epp_s2;
   wire busy_s;
   wire nack_s;
   wire epp_active;
   wire epp_is_read;
   reg nack_prev;

   assign pin_raw = {busy_i, nack_i, perror_i, select_i, nfault_i, plh_i};
   assign epp_raw = {epp_cycle_i, epp_read_i};

   // nAck idles high; its stages reset high so no false edge follows reset
   ppsc_sync2 #(
      .WIDTH(6),
      .RST_VAL(`PPSC_PIN_RESET)
   ) u_pin_sync (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .d_i(pin_raw),
      .q_o(pin_s2)
   );

   // EPP strobes come from the port sequencer in another timing context
   ppsc_sync2 #(
      .WIDTH(2),
      .RST_VAL(2'h0)
   ) u_epp_sync (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .d_i(epp_raw),
      .q_o(epp_s2)
   );

   assign busy_s = pin_s2[5];
   assign nack_s = pin_s2[4];
   assign epp_active = epp_s2[1];
   assign epp_is_read = epp_s2[0];

   // Last cycle's nAck, reset to its idle level
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         nack_prev <= 1'b1;
      end else begin
         nack_prev <= nack_s;
      end
   end

   // ***********************************************
   // Control register
   // ***********************************************
   reg [7:0] control;
   wire wr_control = wr_i && (addr_i == `PPSC_ADDR_CONTROL);
   wire rd_status = rd_i && (addr_i == `PPSC_ADDR_STATUS);

   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         control <= `PPSC_CONTROL_RESET;
      end else if (wr_control) begin
         control <= wdata_i;
      end
   end

   // ***********************************************
   // EPP time-out
   // ***********************************************
   reg [`PPSC_CNT_W-1:0] to_cnt;
   reg to_flag;
   reg to_fired;
   wire to_hit = epp_active && !to_fired && (to_cnt == `PPSC_TIMEOUT_CYC);

   // Counter rests at the limit until the cycle ends
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         to_cnt <= {`PPSC_CNT_W{1'b0}};
      end else if (!epp_active) begin
         to_cnt <= {`PPSC_CNT_W{1'b0}};
      end else if (!to_fired && !to_hit) begin
         to_cnt <= to_cnt + 1'b1;
      end
   end

   // One shot per EPP cycle; a dropped cycle rearms it
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         to_fired <= 1'b0;
      end else if (!epp_active) begin
         to_fired <= 1'b0;
      end else if (to_hit) begin
         to_fired <= 1'b1;
      end
   end

   // Set wins over a clearing read in the same cycle
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         to_flag <= 1'b0;
      end else if (to_hit) begin
         to_flag <= 1'b1;
      end else if (rd_status) begin
         to_flag <= 1'b0;
      end
   end

   // ***********************************************
   // Status view
   // ***********************************************
   // Reserved bit reads zero; status writes have no decode at all
   reg [7:0] status;
   always @* begin
      status = 8'h00;
      status[`PPSC_ST_NBUSY] = ~busy_s;
      status[`PPSC_ST_NACK] = nack_s;
      status[`PPSC_ST_PERROR] = pin_s2[3];
      status[`PPSC_ST_SELECT] = pin_s2[2];
      status[`PPSC_ST_NFAULT] = pin_s2[1];
      status[`PPSC_ST_RSVD] = 1'b0;
      status[`PPSC_ST_PLH] = pin_s2[0];
      status[`PPSC_ST_TIMEOUT] = to_flag;
   end

   // ***********************************************
   // Interrupt status
   // ***********************************************
   wire ack_rise = nack_s && !nack_prev && control[`PPSC_CT_INT_EN];
   wire to_irq = to_hit && !control[`PPSC_CT_EPP_TIMEOUT_IRQ_MASK];

   // Ack edge: set wins over any read in the same cycle
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ack_edge_irq_flag_o <= 1'b0;
      end else if (ack_rise) begin
         ack_edge_irq_flag_o <= 1'b1;
      end else if (rd_i) begin
         ack_edge_irq_flag_o <= 1'b0;
      end
   end

   // Masked by bit 6 alone; software is expected to pair it with bit 4
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         epp_timeout_irq_o <= 1'b0;
      end else if (to_irq) begin
         epp_timeout_irq_o <= 1'b1;
      end else if (rd_i) begin
         epp_timeout_irq_o <= 1'b0;
      end
   end

   // ***********************************************
   // Direction
   // ***********************************************
   reg next_data_in;
   always @* begin
      case (mode_i)
         `PPSC_MODE_BIDIR: next_data_in = control[`PPSC_CT_DIR];
         `PPSC_MODE_ECP: next_data_in = control[`PPSC_CT_DIR];
         `PPSC_MODE_EPP: next_data_in = epp_active && epp_is_read;
         default: next_data_in = 1'b0;
      endcase
   end

   // ***********************************************
   // Read data
   // ***********************************************
   reg [7:0] next_rdata;
   always @* begin
      case (addr_i)
         `PPSC_ADDR_STATUS: next_rdata = status;
         `PPSC_ADDR_CONTROL: next_rdata = control;
         default: next_rdata = 8'h00;
      endcase
   end

   // Holds between reads so a slow consumer can still pick it up
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         rdata_o <= next_rdata;
      end
   end

   // ***********************************************
   // Port lines
   // ***********************************************
   // Reset levels follow the control reset value so the pins never glitch
   localparam [7:0] CTL_RST = `PPSC_CONTROL_RESET;

   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hlh_o <= CTL_RST[`PPSC_CT_HLH];
         nselectin_o <= ~CTL_RST[`PPSC_CT_SELIN];
         ninit_o <= CTL_RST[`PPSC_CT_NINIT];
         nautofd_o <= ~CTL_RST[`PPSC_CT_AUTOFD];
         nstrobe_o <= ~CTL_RST[`PPSC_CT_STROBE];
      end else begin
         hlh_o <= control[`PPSC_CT_HLH];
         nselectin_o <= ~control[`PPSC_CT_SELIN];
         ninit_o <= control[`PPSC_CT_NINIT];
         nautofd_o <= ~control[`PPSC_CT_AUTOFD];
         nstrobe_o <= ~control[`PPSC_CT_STROBE];
      end
   end

   // ***********************************************
   // Direction and report
   // ***********************************************
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         data_in_o <= 1'b0;
      end else begin
         data_in_o <= next_data_in;
      end
   end

   // Report is refreshed every cycle; it never clears any flag
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_report_o <= 16'h0000;
      end else begin
         irq_report_o <= {control, status};
      end
   end

endmodule

// ***********************************************
// Two-stage synchroniser
// ***********************************************
module ppsc_sync2 #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   input wire mclk_i,
   input wire nrst_i,
   input wire [WIDTH-1:0] d_i,
   output wire [WIDTH-1:0] q_o
);

   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;

   // Only the second stage is read; the first may be metastable
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stage1 <= RST_VAL;
         stage2 <= RST_VAL;
      end else begin
         stage1 <= d_i;
         stage2 <= stage1;
      end
   end

   assign q_o = stage2;

endmodule
